// ===== anvr_pkg.sv
package anvr_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 8000; // 125 MHz reference clock
    localparam int STARTUP_NS = 2000000; // Startup wait after power good
    localparam int STARTUP_CYC = (STARTUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int READ_CYCLE_NS = 45; // Read cycle time
    localparam int ADDR_ACCESS_NS = 45; // Address and enable access time
    localparam int OE_TO_DATA_VALID_NS = 20; // Output enable access time
    localparam int CE_RELEASE_TO_FLOAT_NS = 15; // Bus float after enable rises
    localparam int OE_RELEASE_TO_FLOAT_NS = 15; // Bus float after output enable rises
    localparam int ADDR_CHANGE_DATA_HOLD_NS = 3; // Old data hold after address change
    // Minimums rounded up to whole cycles
    localparam int READ_CYCLE_CYC = (READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACCESS_CYC = (ADDR_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FLOAT_CYC = (CE_RELEASE_TO_FLOAT_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    // Two synchroniser stages on the returned data
    localparam int SYNC_CYC = 2;
    localparam int SAMPLE_CYC = ACCESS_CYC + SYNC_CYC;
    localparam int CNT_W = 8; // Width of the cycle counter
    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ANVR_WAIT = 3'b000,
        ANVR_IDLE = 3'b001,
        ANVR_READ = 3'b010,
        ANVR_RECOVER = 3'b011,
        ANVR_WRITE = 3'b100
    } anvr_state_e;
endpackage

// ===== anvr_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Startup timer link
// ----------------------------------------
interface anvr_timer_if;
    logic power_good; // Both supplies above minimum
    logic start_done; // Startup interval has passed
    modport ctrl (output power_good, input start_done);
    modport timer (input power_good, output start_done);
endinterface
`default_nettype wire

// ===== anvr_startup_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Startup timer: counts the wait after power good
// ----------------------------------------
module anvr_startup_timer #(
    parameter int STARTUP_CYCLES = anvr_pkg::STARTUP_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    anvr_timer_if.timer tmr
);
    localparam int W = $clog2(STARTUP_CYCLES + 1);
    initial
    begin
        if (STARTUP_CYCLES < 1)
            $error("STARTUP_CYCLES must be at least one");
    end
    logic [W-1:0] cnt_reg; // Cycles since power good
    logic done_reg; // Wait complete
    wire at_end = (cnt_reg == W'(STARTUP_CYCLES - 1));
    // Any power loss restarts the full wait
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end
        else if (!tmr.power_good)
        begin
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end
        else if (!done_reg)
        begin
            cnt_reg <= cnt_reg + W'(1);
            done_reg <= at_end;
        end
    end
    assign tmr.start_done = done_reg;
    // Done never rises before the full count
    property p_no_early_done;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(done_reg) |-> $past(at_end) && $past(tmr.power_good);
    endproperty
    a_no_early_done: assert property (p_no_early_done)
        else $error("startup done rose early");
    // Power loss clears done next cycle
    property p_brownout_clears;
        @(posedge ref_clk) disable iff (!resetn)
        !tmr.power_good |=> !done_reg && cnt_reg == '0;
    endproperty
    a_brownout_clears: assert property (p_brownout_clears)
        else $error("startup wait not restarted after power loss");
endmodule
`default_nettype wire

// ===== anvr_host.sv
`timescale 1ns/1ps
`default_nettype none
module anvr_host #(
    parameter int ADDR_W = 15,
    parameter int STARTUP_CYCLES = anvr_pkg::STARTUP_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic power_good,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_burst,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic mem_ce_n,
    output logic mem_we_n,
    output logic mem_oe_n,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_dq_i,
    output logic [7:0] mem_dq_o,
    output logic mem_dq_oe
);
    // ----------------------------------------
    // Elaboration checks and constants
    // ----------------------------------------
    initial
    begin
        if (ADDR_W < 1 || ADDR_W > 32)
            $error("ADDR_W out of range");
    end
    localparam int CW = anvr_pkg::CNT_W;
    localparam logic [CW-1:0] SAMPLE_AT = CW'(anvr_pkg::SAMPLE_CYC);
    localparam logic [CW-1:0] CYCLE_MIN = CW'(anvr_pkg::READ_CYCLE_CYC);
    localparam logic [CW-1:0] FLOAT_MIN = CW'(anvr_pkg::FLOAT_CYC);
    localparam logic [CW-1:0] WRITE_LEN = CW'(anvr_pkg::READ_CYCLE_CYC);
    // ----------------------------------------
    // Startup timer
    // ----------------------------------------
    anvr_timer_if tif ();
    logic [1:0] pg_sync_reg; // Power good synchroniser
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            pg_sync_reg <= 2'h0;
        else
            pg_sync_reg <= {pg_sync_reg[0], power_good};
    end
    assign tif.power_good = pg_sync_reg[1];
    anvr_startup_timer #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_timer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .tmr(tif)
    );
    // ----------------------------------------
    // Returned data synchroniser
    // ----------------------------------------
    logic [7:0] dq_s1_reg; // First stage, read only by second
    logic [7:0] dq_s2_reg; // Second stage
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dq_s1_reg <= 8'h00;
            dq_s2_reg <= 8'h00;
        end
        else
        begin
            dq_s1_reg <= mem_dq_i;
            dq_s2_reg <= dq_s1_reg;
        end
    end
    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    anvr_pkg::anvr_state_e state_reg, state_next;
    logic [CW-1:0] cnt_reg, cnt_next; // Cycles in current phase
    logic burst_reg, burst_next; // Address-controlled read mode
    wire started = tif.start_done;
    wire take_req = (state_reg == anvr_pkg::ANVR_IDLE) && req_valid && started;
    wire read_take = (state_reg == anvr_pkg::ANVR_READ) && (cnt_reg == SAMPLE_AT);
    wire cycle_done = (cnt_reg >= CYCLE_MIN) && (cnt_reg >= SAMPLE_AT);
    wire burst_more = burst_reg && req_valid && !req_write && req_burst;
    wire write_end = (state_reg == anvr_pkg::ANVR_WRITE) && (cnt_reg == WRITE_LEN);
    // Next state decode
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg + CW'(1);
        burst_next = burst_reg;
        case (state_reg)
            anvr_pkg::ANVR_WAIT:
            begin
                cnt_next = '0;
                if (started)
                    state_next = anvr_pkg::ANVR_IDLE;
            end
            anvr_pkg::ANVR_IDLE:
            begin
                cnt_next = '0;
                if (!started)
                    state_next = anvr_pkg::ANVR_WAIT;
                else if (take_req)
                begin
                    state_next = req_write ? anvr_pkg::ANVR_WRITE : anvr_pkg::ANVR_READ;
                    burst_next = req_burst && !req_write;
                end
            end
            anvr_pkg::ANVR_READ:
            begin
                if (cycle_done)
                begin
                    cnt_next = '0;
                    // Next address with enables held low
                    if (burst_more)
                        state_next = anvr_pkg::ANVR_READ;
                    else
                        state_next = anvr_pkg::ANVR_RECOVER;
                end
            end
            anvr_pkg::ANVR_WRITE:
            begin
                if (write_end)
                begin
                    cnt_next = '0;
                    state_next = anvr_pkg::ANVR_RECOVER;
                end
            end
            anvr_pkg::ANVR_RECOVER:
            begin
                // Bus float time before anyone drives again
                if (cnt_reg >= FLOAT_MIN)
                begin
                    cnt_next = '0;
                    state_next = anvr_pkg::ANVR_IDLE;
                    burst_next = 1'b0;
                end
            end
            default:
            begin
                state_next = anvr_pkg::ANVR_WAIT;
                cnt_next = '0;
            end
        endcase
        // Power loss aborts everything
        if (!started)
        begin
            state_next = anvr_pkg::ANVR_WAIT;
            cnt_next = '0;
            burst_next = 1'b0;
        end
    end
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= anvr_pkg::ANVR_WAIT;
            cnt_reg <= '0;
            burst_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            burst_reg <= burst_next;
        end
    end
    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    wire in_read = (state_next == anvr_pkg::ANVR_READ);
    wire in_write = (state_next == anvr_pkg::ANVR_WRITE);
    wire new_addr = take_req || (read_take && cycle_done && burst_more);
    wire wr_pulse = in_write && (state_reg == anvr_pkg::ANVR_WRITE) && !write_end;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mem_ce_n <= 1'b1;
            mem_we_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_dq_oe <= 1'b0;
            mem_dq_o <= 8'h00;
            mem_addr <= '0;
        end
        else
        begin
            mem_ce_n <= !(in_read || in_write);
            mem_we_n <= !wr_pulse;
            mem_oe_n <= !in_read;
            mem_dq_oe <= in_write;
            if (new_addr)
                mem_addr <= req_addr;
            if (take_req && req_write)
                mem_dq_o <= req_wdata;
        end
    end
    // ----------------------------------------
    // Request and answer ports
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
        end
        else
        begin
            req_ready <= (state_next == anvr_pkg::ANVR_IDLE) && started;
            rsp_valid <= read_take;
            if (read_take)
                rsp_rdata <= dq_s2_reg;
        end
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_we_high_in_read;
        @(posedge ref_clk) disable iff (!resetn)
        !mem_oe_n |-> mem_we_n;
    endproperty
    a_we_high_in_read: assert property (p_we_high_in_read)
        else $error("write enable low during read");
    property p_no_drive_with_oe;
        @(posedge ref_clk) disable iff (!resetn)
        !mem_oe_n |-> !mem_dq_oe;
    endproperty
    a_no_drive_with_oe: assert property (p_no_drive_with_oe)
        else $error("host drives bus while output enable low");
    property p_idle_before_start;
        @(posedge ref_clk) disable iff (!resetn)
        !started |=> mem_ce_n && mem_we_n;
    endproperty
    a_idle_before_start: assert property (p_idle_before_start)
        else $error("enables low before startup complete");
    property p_addr_stable_in_cycle;
        @(posedge ref_clk) disable iff (!resetn)
        !mem_ce_n && $past(!mem_ce_n) && !$past(new_addr) |-> $stable(mem_addr);
    endproperty
    a_addr_stable_in_cycle: assert property (p_addr_stable_in_cycle)
        else $error("address moved within a cycle");
    property p_sample_late_enough;
        @(posedge ref_clk) disable iff (!resetn)
        rsp_valid |-> $past(!mem_oe_n, 2) && !$past(mem_ce_n, 2);
    endproperty
    a_sample_late_enough: assert property (p_sample_late_enough)
        else $error("read data taken outside a read");
endmodule
`default_nettype wire

// ===== anvr_nvram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Byte-wide memory device model
// ----
module anvr_nvram_model (
    input wire logic power_good,
    input wire logic slow,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [14:0] addr,
    input wire logic [7:0] dq_host,
    output logic [7:0] dq
);
    logic [7:0] mem [0:32767]; // Storage array
    logic [7:0] rd_q = 8'h00; // Byte on the read path
    logic [7:0] pend = 8'h00; // Byte seen during a write
    logic [14:0] pend_a = 15'h0000; // Address seen during a write
    logic drv = 1'b0; // Device drives the pins
    wire rd_on = !ce_n && !oe_n && we_n; // Read mode decode
    wire wr_on = !ce_n && !we_n; // Write mode decode
    // Released pins show the inverse, which is the old byte while rd_q is scrambled
    assign dq = drv ? rd_q : ~rd_q;
    // Drive starts no sooner than 3 ns, stops within 15 ns
    always @(rd_on)
        if (rd_on)
            drv <= #3 1'b1;
        else
            drv <= #15 1'b0;
    // Output enable access, fast or slow
    always @(negedge oe_n)
        rd_q <= #(slow ? 20 : 4) mem[addr];
    // Old byte held 3 ns, then scrambled until new byte
    always @(addr)
    begin
        rd_q <= #3 ~rd_q;
        rd_q <= #(slow ? 45 : 12) mem[addr];
    end
    // Capture byte and address during the write overlap
    always @(dq_host or addr or wr_on)
        if (wr_on)
        begin
            pend = dq_host;
            pend_a = addr;
        end
    // Commit only while both supplies are good
    always @(negedge wr_on)
        if (power_good)
            mem[pend_a] = pend;
endmodule
`default_nettype wire

// ===== anvr_host_test.sv
`timescale 1ns/1ps
`default_nettype none
module anvr_host_test;
    // ----
    // Signals
    // ----
    localparam int START_CYC = 20; // Shortened startup wait
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic power_good = 1'b0;
    logic slow = 1'b0; // Device answers at its limit
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_burst = 1'b0;
    logic [14:0] req_addr = 15'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready, rsp_valid, mem_ce_n, mem_we_n, mem_oe_n, mem_dq_oe;
    logic [7:0] rsp_rdata, mem_dq_o, dev_dq;
    logic [14:0] mem_addr;
    wire logic [7:0] mem_dq_i = mem_dq_oe ? mem_dq_o : dev_dq; // Resolved pins
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int ce_rises = 0;
    int n;
    logic [31:0] seed = 32'h926FF073;
    logic [7:0] shadow [logic [14:0]]; // Bytes written so far
    logic [14:0] addrs [8];
    always #4 ref_clk = ~ref_clk;
    // ----
    // Design and device
    // ----
    anvr_host #(.ADDR_W(15), .STARTUP_CYCLES(START_CYC)) i_anvr_host (.ref_clk(ref_clk),
        .resetn(resetn), .power_good(power_good), .req_valid(req_valid),
        .req_write(req_write), .req_burst(req_burst), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n),
        .mem_oe_n(mem_oe_n), .mem_addr(mem_addr), .mem_dq_i(mem_dq_i),
        .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));
    anvr_nvram_model i_anvr_nvram_model (.power_good(power_good), .slow(slow),
        .ce_n(mem_ce_n), .we_n(mem_we_n), .oe_n(mem_oe_n), .addr(mem_addr),
        .dq_host(mem_dq_o), .dq(dev_dq));
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] expect_byte(input logic [14:0] a);
        return shadow.exists(a) ? shadow[a] : 8'h00;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Count cycles from supply good to ready, chip and write enables held high
    task automatic startup_wait(output int cnt);
        cnt = 0;
        while (req_ready !== 1'b1 && cnt < 100)
        begin
            @(negedge ref_clk);
            cnt++;
            check({mem_ce_n, mem_we_n}, 2'b11);
        end
        check(req_ready, 1'b1);
    endtask
    // One request, held until taken; reads compared
    task automatic access(input logic wr, input logic br, input logic [14:0] a,
        input logic [7:0] d);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 200)
        begin
            @(negedge ref_clk);
            k++;
        end
        check(req_ready, 1'b1);
        req_valid = 1'b1;
        req_write = wr;
        req_burst = br;
        req_addr = a;
        req_wdata = d;
        @(negedge ref_clk);
        req_valid = 1'b0;
        if (wr)
            shadow[a] = d;
        else
        begin
            k = 0;
            while (rsp_valid !== 1'b1 && k < 40)
            begin
                @(negedge ref_clk);
                k++;
            end
            check(rsp_valid, 1'b1);
            check(rsp_rdata, expect_byte(a));
        end
        repeat (2) @(negedge ref_clk);
    endtask
    // ----
    // Pin monitor and timeout
    // ----
    always @(posedge mem_ce_n)
        ce_rises++;
    always @(negedge ref_clk)
    begin
        cycles++;
        if (!mem_oe_n && !mem_ce_n)
        begin
            check(mem_dq_oe, 1'b0);
            check(mem_we_n, 1'b1);
        end
        if (cycles == 3000)
        begin
            fail_count++;
            end_of_test();
        end
    end
    // ----
    // Main sequence
    // ----
    initial
    begin
        repeat (5) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        power_good = 1'b1;
        startup_wait(n);
        check(n >= START_CYC, 1'b1);
        // Corner and random writes, read back fast and slow
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            addrs[i] = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7FFF : seed[14:0];
            access(1'b1, 1'b0, addrs[i], seed[22:15]);
        end
        for (int i = 0; i < 8; i++)
        begin
            slow = i[0];
            access(1'b0, 1'b0, addrs[i], 8'h00);
        end
        // Address-controlled burst keeps enable low
        // Next address held until the answer edge that takes it
        n = 0;
        while (req_ready !== 1'b1 && n < 200)
        begin
            @(negedge ref_clk);
            n++;
        end
        check(req_ready, 1'b1);
        ce_rises = 0;
        req_valid = 1'b1;
        req_write = 1'b0;
        req_burst = 1'b1;
        req_addr = addrs[7];
        @(negedge ref_clk);
        req_addr = addrs[6];
        for (int i = 0; i < 4; i++)
        begin
            n = 0;
            while (rsp_valid !== 1'b1 && n < 40)
            begin
                @(negedge ref_clk);
                n++;
            end
            check(rsp_valid, 1'b1);
            check(rsp_rdata, expect_byte(addrs[7 - i]));
            // Queue the next address, or end the burst
            if (i < 2)
                req_addr = addrs[5 - i];
            else
                req_valid = 1'b0;
            @(negedge ref_clk);
        end
        req_burst = 1'b0;
        check(ce_rises, 1);
        // Supply loss in mid-write blocks the write
        access(1'b1, 1'b0, addrs[1], ~expect_byte(addrs[1]));
        shadow[addrs[1]] = ~shadow[addrs[1]];
        power_good = 1'b0;
        repeat (6) @(negedge ref_clk);
        check(req_ready, 1'b0);
        power_good = 1'b1;
        startup_wait(n);
        check(n >= START_CYC, 1'b1);
        for (int i = 0; i < 3; i++)
            access(1'b0, 1'b0, addrs[i], 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
